// ---- verilog/pcs_pkg.sv ----
`default_nettype none

package pcs_pkg;

	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned REG_W    = 8;
	localparam int unsigned NUM_CHAN = 6;

	// ----------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------
	localparam logic [5:0] IDX_CLOCK_SELECT      = 6'h02;
	localparam logic [5:0] IDX_PRESCALE_SELECT   = 6'h03;
	localparam logic [5:0] IDX_MODULATOR_CONTROL = 6'h05;
	localparam logic [5:0] IDX_FACTORY_TEST_ONE  = 6'h06;
	localparam logic [5:0] IDX_FACTORY_TEST_TWO  = 6'h07;
	localparam logic [5:0] IDX_SCALE_VALUE_A     = 6'h08;
	localparam logic [5:0] IDX_SCALE_VALUE_B     = 6'h09;
	localparam logic [5:0] IDX_CLOCK_STATUS      = 6'h20;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned BIT_JOIN_PAIR_HI      = 6;
	localparam int unsigned BIT_JOIN_PAIR_MID     = 5;
	localparam int unsigned BIT_JOIN_PAIR_LO      = 4;
	localparam int unsigned BIT_WAIT_CLOCK_STOP   = 3;
	localparam int unsigned BIT_FREEZE_CLOCK_STOP = 2;
	localparam int unsigned POS_PRESCALE_SELECT_B = 4;
	localparam int unsigned POS_PRESCALE_SELECT_A = 0;
	localparam logic [7:0]  MASK_CONTROL          = 8'h7C;
	localparam logic [7:0]  MASK_CLOCK_SELECT     = 8'h3F;
	localparam logic [7:0]  MASK_PRESCALE         = 8'h77;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_REG       = 8'h00;
	localparam logic [6:0] RST_PRESCALER = 7'h00;
	localparam logic [7:0] RST_SCALE_CNT = 8'h00;

	// ----------------------------------------
	// divider figures
	// ----------------------------------------
	localparam int unsigned PRESCALE_W   = 7;
	localparam logic [7:0]  SCALE_TERM   = 8'h01;
	localparam logic [7:0]  SCALE_STEP   = 8'h01;

	// ----------------------------------------
	// bus answers
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ---- verilog/pcs_scale_divider.sv ----
`default_nettype none

// down-counter reloaded from the scale value, feeding a divide-by-two stage
module pcs_scale_divider
	import pcs_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       tick_in,
	input  wire logic       load,
	input  wire logic [7:0] load_value,
	input  wire logic [7:0] scale_value,
	output logic            scaled_level,
	output logic            scaled_tick
);

	typedef struct packed {
		logic [7:0] cnt;
		logic       half;
	} pcs_div_s;

	pcs_div_s st_q;
	pcs_div_s st_d;
	logic     term;

	assign term = tick_in && (st_q.cnt == SCALE_TERM);

	always_comb begin
		st_d = st_q;
		if (load) begin
			st_d.cnt = load_value;
		end else if (term) begin
			// a zero scale wraps through 255 so it counts 256 ticks
			st_d.cnt  = scale_value;
			st_d.half = ~st_q.half;
		end else if (tick_in) begin
			st_d.cnt = st_q.cnt - SCALE_STEP;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '{cnt: RST_SCALE_CNT, half: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign scaled_level = st_q.half;
	assign scaled_tick  = term && !st_q.half;

endmodule

`default_nettype wire

// ---- verilog/pcs_control.sv ----
// The AXI4-Lite interface to the registers was chosen for this implementation.
`default_nettype none

module pcs_control
	import pcs_pkg::*;
(
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [pcs_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [pcs_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [pcs_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [pcs_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        wait_mode,
	input  wire logic                        freeze_mode,
	input  wire logic                        special_mode,
	output logic                             clk_a_tick,
	output logic                             clk_b_tick,
	output logic                             clk_sa_tick,
	output logic                             clk_sb_tick,
	output logic [pcs_pkg::NUM_CHAN-1:0]     chan_clk_tick,
	output logic                             join_pair_lo,
	output logic                             join_pair_mid,
	output logic                             join_pair_hi,
	output logic [pcs_pkg::NUM_CHAN-1:0]     chan_pin_active,
	output logic [pcs_pkg::NUM_CHAN-1:0]     chan_ctrl_source,
	output logic                             prescaler_running
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic                    aw_held;
		logic [ADDR_W-1:0]       aw_addr;
		logic                    w_held;
		logic [DATA_W-1:0]       w_data;
		logic [3:0]              w_strb;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [DATA_W-1:0]       rdata;
		logic [1:0]              rresp;
		logic [REG_W-1:0]        clock_select;
		logic [REG_W-1:0]        prescale_select;
		logic [REG_W-1:0]        modulator_control;
		logic [REG_W-1:0]        factory_test_one;
		logic [REG_W-1:0]        factory_test_two;
		logic [REG_W-1:0]        scale_value_a;
		logic [REG_W-1:0]        scale_value_b;
		logic [PRESCALE_W-1:0]   prescaler;
		logic                    tick_a;
		logic                    tick_b;
		logic                    tick_sa;
		logic                    tick_sb;
		logic [NUM_CHAN-1:0]     chan_tick;
		logic                    running;
	} pcs_state_s;

	pcs_state_s st_q;
	pcs_state_s st_d;

	// ----------------------------------------
	// combinational helpers
	// ----------------------------------------
	logic                  do_write;
	logic [5:0]            wr_idx;
	logic [5:0]            rd_idx;
	logic [REG_W-1:0]      wr_byte;
	logic                  wr_lane;
	logic                  wr_hit;
	logic                  load_a;
	logic                  load_b;
	logic                  run_en;
	logic [2:0]            sel_a;
	logic [2:0]            sel_b;
	logic [PRESCALE_W-1:0] mask_a;
	logic [PRESCALE_W-1:0] mask_b;
	logic                  tick_a_raw;
	logic                  tick_b_raw;
	logic                  sa_level;
	logic                  sb_level;
	logic                  sa_tick_raw;
	logic                  sb_tick_raw;
	logic [NUM_CHAN-1:0]   eff_select;
	logic [NUM_CHAN-1:0]   tick_next;
	logic [REG_W-1:0]      rd_byte;
	logic                  rd_hit;
	logic                  j_lo;
	logic                  j_mid;
	logic                  j_hi;

	// ----------------------------------------
	// write path
	// ----------------------------------------
	// a write fires once both address and data are held and no response waits
	assign do_write = st_q.aw_held && st_q.w_held && !st_q.bvalid;
	assign wr_idx   = st_q.aw_addr[7:2];
	assign wr_byte  = st_q.w_data[REG_W-1:0];
	assign wr_lane  = st_q.w_strb[0];
	assign load_a   = do_write && wr_lane && (wr_idx == IDX_SCALE_VALUE_A);
	assign load_b   = do_write && wr_lane && (wr_idx == IDX_SCALE_VALUE_B);

	always_comb begin
		unique case (wr_idx)
			IDX_CLOCK_SELECT,
			IDX_PRESCALE_SELECT,
			IDX_MODULATOR_CONTROL,
			IDX_FACTORY_TEST_ONE,
			IDX_FACTORY_TEST_TWO,
			IDX_SCALE_VALUE_A,
			IDX_SCALE_VALUE_B,
			IDX_CLOCK_STATUS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// prescaler gating and clocks A and B
	// ----------------------------------------
	assign j_lo  = st_q.modulator_control[BIT_JOIN_PAIR_LO];
	assign j_mid = st_q.modulator_control[BIT_JOIN_PAIR_MID];
	assign j_hi  = st_q.modulator_control[BIT_JOIN_PAIR_HI];

	// the gate acts the cycle the mode input changes, so nothing counts in it
	assign run_en = !(wait_mode && st_q.modulator_control[BIT_WAIT_CLOCK_STOP])
		&& !(freeze_mode && st_q.modulator_control[BIT_FREEZE_CLOCK_STOP]);

	assign sel_a  = st_q.prescale_select[POS_PRESCALE_SELECT_A +: 3];
	assign sel_b  = st_q.prescale_select[POS_PRESCALE_SELECT_B +: 3];
	assign mask_a = PRESCALE_W'((8'h01 << sel_a) - 8'h01);
	assign mask_b = PRESCALE_W'((8'h01 << sel_b) - 8'h01);

	// one shared counter keeps A and B phase-aligned, like a ripple prescaler
	assign tick_a_raw = run_en && ((st_q.prescaler & mask_a) == mask_a);
	assign tick_b_raw = run_en && ((st_q.prescaler & mask_b) == mask_b);

	// ----------------------------------------
	// scaled clocks SA and SB
	// ----------------------------------------
	pcs_scale_divider u_div_a (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.tick_in      (tick_a_raw),
		.load         (load_a),
		.load_value   (wr_byte),
		.scale_value  (st_q.scale_value_a),
		.scaled_level (sa_level),
		.scaled_tick  (sa_tick_raw)
	);

	pcs_scale_divider u_div_b (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.tick_in      (tick_b_raw),
		.load         (load_b),
		.load_value   (wr_byte),
		.scale_value  (st_q.scale_value_b),
		.scaled_level (sb_level),
		.scaled_tick  (sb_tick_raw)
	);

	// ----------------------------------------
	// channel clock routing
	// ----------------------------------------
	// in a joined pair the high-byte channel follows the low-byte select
	always_comb begin
		eff_select    = st_q.clock_select[NUM_CHAN-1:0];
		eff_select[0] = j_lo ? eff_select[1] : eff_select[0];
		eff_select[2] = j_mid ? eff_select[3] : eff_select[2];
		eff_select[4] = j_hi ? eff_select[5] : eff_select[4];
		tick_next[0]  = eff_select[0] ? sa_tick_raw : tick_a_raw;
		tick_next[1]  = eff_select[1] ? sa_tick_raw : tick_a_raw;
		tick_next[2]  = eff_select[2] ? sb_tick_raw : tick_b_raw;
		tick_next[3]  = eff_select[3] ? sb_tick_raw : tick_b_raw;
		tick_next[4]  = eff_select[4] ? sa_tick_raw : tick_a_raw;
		tick_next[5]  = eff_select[5] ? sa_tick_raw : tick_a_raw;
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	assign rd_idx = s_axi_araddr[7:2];

	always_comb begin
		rd_byte = RST_REG;
		rd_hit  = 1'b1;
		unique case (rd_idx)
			IDX_CLOCK_SELECT:      rd_byte = st_q.clock_select;
			IDX_PRESCALE_SELECT:   rd_byte = st_q.prescale_select;
			IDX_MODULATOR_CONTROL: rd_byte = st_q.modulator_control;
			IDX_FACTORY_TEST_ONE:  rd_byte = special_mode ? st_q.factory_test_one
				: RST_REG;
			IDX_FACTORY_TEST_TWO:  rd_byte = special_mode ? st_q.factory_test_two
				: RST_REG;
			IDX_SCALE_VALUE_A:     rd_byte = st_q.scale_value_a;
			IDX_SCALE_VALUE_B:     rd_byte = st_q.scale_value_b;
			IDX_CLOCK_STATUS:      rd_byte = {5'h00, st_q.running, sb_level, sa_level};
			default:               rd_hit  = 1'b0;
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_d = st_q;

		// address and data channels are taken independently
		if (s_axi_awvalid && !st_q.aw_held) begin
			st_d.aw_held = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_q.w_held) begin
			st_d.w_held = 1'b1;
			st_d.w_data = s_axi_wdata;
			st_d.w_strb = s_axi_wstrb;
		end

		if (do_write) begin
			st_d.aw_held = 1'b0;
			st_d.w_held  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
			if (wr_lane) begin
				unique case (wr_idx)
					IDX_CLOCK_SELECT:
						st_d.clock_select = wr_byte & MASK_CLOCK_SELECT;
					IDX_PRESCALE_SELECT:
						st_d.prescale_select = wr_byte & MASK_PRESCALE;
					IDX_MODULATOR_CONTROL:
						// bits take effect at once; software guards the change
						st_d.modulator_control = wr_byte & MASK_CONTROL;
					IDX_FACTORY_TEST_ONE:
						if (special_mode) begin
							st_d.factory_test_one = wr_byte;
						end
					IDX_FACTORY_TEST_TWO:
						if (special_mode) begin
							st_d.factory_test_two = wr_byte;
						end
					IDX_SCALE_VALUE_A: st_d.scale_value_a = wr_byte;
					IDX_SCALE_VALUE_B: st_d.scale_value_b = wr_byte;
					default:
						st_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR; // status is read-only
				endcase
			end
		end else if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end

		if (s_axi_arvalid && !st_q.rvalid) begin
			st_d.rvalid = 1'b1;
			st_d.rdata  = {{(DATA_W-REG_W){1'b0}}, rd_byte};
			st_d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end

		if (run_en) begin
			st_d.prescaler = st_q.prescaler + PRESCALE_W'(1);
		end

		st_d.running   = run_en;
		st_d.tick_a    = tick_a_raw;
		st_d.tick_b    = tick_b_raw;
		st_d.tick_sa   = sa_tick_raw;
		st_d.tick_sb   = sb_tick_raw;
		st_d.chan_tick = tick_next;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '{
				aw_held:           1'b0,
				aw_addr:           '0,
				w_held:            1'b0,
				w_data:            '0,
				w_strb:            4'h0,
				bvalid:            1'b0,
				bresp:             RESP_OKAY,
				rvalid:            1'b0,
				rdata:             '0,
				rresp:             RESP_OKAY,
				clock_select:      RST_REG,
				prescale_select:   RST_REG,
				modulator_control: RST_REG,
				factory_test_one:  RST_REG,
				factory_test_two:  RST_REG,
				scale_value_a:     RST_REG,
				scale_value_b:     RST_REG,
				prescaler:         RST_PRESCALER,
				tick_a:            1'b0,
				tick_b:            1'b0,
				tick_sa:           1'b0,
				tick_sb:           1'b0,
				chan_tick:         '0,
				running:           1'b0
			};
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_awready = !st_q.aw_held;
	assign s_axi_wready  = !st_q.w_held;
	assign s_axi_bvalid  = st_q.bvalid;
	assign s_axi_bresp   = st_q.bresp;
	assign s_axi_arready = !st_q.rvalid;
	assign s_axi_rvalid  = st_q.rvalid;
	assign s_axi_rdata   = st_q.rdata;
	assign s_axi_rresp   = st_q.rresp;

	assign clk_a_tick        = st_q.tick_a;
	assign clk_b_tick        = st_q.tick_b;
	assign clk_sa_tick       = st_q.tick_sa;
	assign clk_sb_tick       = st_q.tick_sb;
	assign chan_clk_tick     = st_q.chan_tick;
	assign prescaler_running = st_q.running;

	assign join_pair_lo  = j_lo;
	assign join_pair_mid = j_mid;
	assign join_pair_hi  = j_hi;

	// a joined pair drives only its odd pin; the even pin is released
	assign chan_pin_active = {1'b1, !j_hi, 1'b1, !j_mid, 1'b1, !j_lo};

	// which channel's polarity, enable and alignment bits govern each channel
	assign chan_ctrl_source = {1'b1, j_hi, 1'b1, j_mid, 1'b1, j_lo};

endmodule

`default_nettype wire

// ---- sim/pcs_control_checker.sv ----
`default_nettype none

module pcs_control_checker
	import pcs_pkg::*;
(
	input wire logic                         aclk,
	input wire logic                         aresetn,
	input wire logic                         wait_mode,
	input wire logic                         freeze_mode,
	input wire logic                         clk_a_tick,
	input wire logic                         clk_b_tick,
	input wire logic                         clk_sa_tick,
	input wire logic                         clk_sb_tick,
	input wire logic                         join_pair_lo,
	input wire logic                         join_pair_mid,
	input wire logic                         join_pair_hi,
	input wire logic [pcs_pkg::NUM_CHAN-1:0] chan_pin_active,
	input wire logic [pcs_pkg::NUM_CHAN-1:0] chan_ctrl_source,
	input wire logic                         prescaler_running
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ----------------------------------------
	// pair joining
	// ----------------------------------------
	property p_join_hi;
		chan_pin_active[5:4] == {1'h1, !join_pair_hi}
			&& chan_ctrl_source[5:4] == {1'h1, join_pair_hi};
	endproperty
	a_join_hi: assert property (p_join_hi)
		else $error("pair 4/5 routing wrong");

	property p_join_mid;
		chan_pin_active[3:2] == {1'h1, !join_pair_mid}
			&& chan_ctrl_source[3:2] == {1'h1, join_pair_mid};
	endproperty
	a_join_mid: assert property (p_join_mid)
		else $error("pair 2/3 routing wrong");

	property p_join_lo;
		chan_pin_active[1:0] == {1'h1, !join_pair_lo}
			&& chan_ctrl_source[1:0] == {1'h1, join_pair_lo};
	endproperty
	a_join_lo: assert property (p_join_lo)
		else $error("pair 0/1 routing wrong");

	// ----------------------------------------
	// prescaler gating and scaled clocks
	// ----------------------------------------
	property p_a_needs_run;
		clk_a_tick |-> prescaler_running;
	endproperty
	a_a_needs_run: assert property (p_a_needs_run)
		else $error("clock A ticked while stopped");

	property p_b_needs_run;
		clk_b_tick |-> prescaler_running;
	endproperty
	a_b_needs_run: assert property (p_b_needs_run)
		else $error("clock B ticked while stopped");

	// no mode asks for a stop, so the prescaler must be back one cycle later
	property p_run_free;
		!wait_mode && !freeze_mode |=> prescaler_running;
	endproperty
	a_run_free: assert property (p_run_free) else $error("prescaler not restored");

	property p_sa_gap;
		clk_sa_tick |=> !clk_sa_tick;
	endproperty
	a_sa_gap: assert property (p_sa_gap)
		else $error("clock SA faster than half clock A");

	property p_sb_gap;
		clk_sb_tick |=> !clk_sb_tick;
	endproperty
	a_sb_gap: assert property (p_sb_gap)
		else $error("clock SB faster than half clock B");

	c_join: cover property (join_pair_hi && join_pair_lo);
	c_sa: cover property (clk_sa_tick);
	c_sb: cover property (clk_sb_tick);
	c_stop: cover property (!prescaler_running && (wait_mode || freeze_mode));
endmodule

bind pcs_control pcs_control_checker u_chk (.aclk, .aresetn, .wait_mode, .freeze_mode,
	.clk_a_tick, .clk_b_tick, .clk_sa_tick, .clk_sb_tick, .join_pair_lo, .join_pair_mid,
	.join_pair_hi, .chan_pin_active, .chan_ctrl_source, .prescaler_running);

`default_nettype wire

// ---- sim/pcs_control_tb_top.sv ----
`default_nettype none

module pcs_control_tb_top
	import pcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        wait_mode = 1'h0;
	logic        freeze_mode = 1'h0;
	logic        special_mode = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        clk_a_tick, clk_b_tick, clk_sa_tick, clk_sb_tick, prescaler_running;
	logic        join_pair_lo, join_pair_mid, join_pair_hi;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [5:0]  chan_clk_tick, chan_pin_active, chan_ctrl_source;
	logic [3:0]  tks;
	logic [33:0] rq [$];
	logic [1:0]  bq [$];
	logic [7:0]  ra [7] = '{8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
	logic [7:0]  tr [2] = '{8'h18, 8'h1C};
	int          err_count = 0;
	int          compares = 0;
	int          cyc = 0;

	assign tks = {clk_sb_tick, clk_sa_tick, clk_b_tick, clk_a_tick};

	// strobes and response readies tied: every write uses the full word
	pcs_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'h1), .wait_mode,
		.freeze_mode, .special_mode, .clk_a_tick, .clk_b_tick, .clk_sa_tick, .clk_sb_tick,
		.chan_clk_tick, .join_pair_lo, .join_pair_mid, .join_pair_hi, .chan_pin_active,
		.chan_ctrl_source, .prescaler_running);

	always #5 aclk = ~aclk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic finish_test();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [33:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// handshakes are judged at the falling edge, where ready is settled for the next rise
	task automatic wr(input logic [7:0] a, d, input logic [1:0] r);
		logic aw_t, w_t;
		aw_t = 1'h0;
		w_t = 1'h0;
		bq.push_back(r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(aw_t && w_t)) begin
			@(negedge aclk);
			aw_t = aw_t | (s_axi_awvalid & s_axi_awready);
			w_t = w_t | (s_axi_wvalid & s_axi_wready);
			@(posedge aclk);
			s_axi_awvalid <= !aw_t;
			s_axi_wvalid <= !w_t;
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
	endtask

	task automatic rd(input logic [7:0] a, d, input logic [1:0] r);
		rq.push_back({r, 24'h0, d});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(negedge aclk); while (s_axi_arready !== 1'h1);
		@(posedge aclk);
		s_axi_arvalid <= 1'h0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
	endtask

	task automatic period(input int i, output int n);
		n = 0;
		do @(negedge aclk); while (tks[i] !== 1'h1);
		do begin
			@(negedge aclk);
			n++;
		end while (tks[i] !== 1'h1);
	endtask

	always @(negedge aclk) begin
		if (s_axi_rvalid === 1'h1)
			check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid === 1'h1)
			check("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
	end

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			finish_test();
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		int n;
		logic [7:0] c, v;
		void'($urandom(32'h4536));
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		foreach (ra[i]) rd(ra[i], 8'h00, RESP_OKAY);
		// every stop-bit and mode combination, join bits random
		for (int k = 0; k < 16; k++) begin
			c = 8'($urandom);
			c[3:2] = k[3:2];
			wr(8'h14, c, RESP_OKAY); // modulator control, stop bits taken from k
			rd(8'h14, c & MASK_CONTROL, RESP_OKAY);
			@(posedge aclk);
			wait_mode <= k[1];
			freeze_mode <= k[0];
			repeat (3) @(negedge aclk);
			n = !(k[1] && c[3]) && !(k[0] && c[2]);
			check("running", {33'h0, prescaler_running}, 34'(n));
			check("a tick", {33'h0, clk_a_tick}, 34'(n));
			check("joins", 34'({join_pair_hi, join_pair_mid, join_pair_lo}), 34'(c[6:4]));
			check("pins", 34'(chan_pin_active), 34'({1'h1, !c[6], 1'h1, !c[5], 1'h1, !c[4]}));
			check("ctrl src", 34'(chan_ctrl_source), 34'({1'h1, c[6], 1'h1, c[5], 1'h1, c[4]}));
		end
		@(posedge aclk);
		wait_mode <= 1'h0;
		freeze_mode <= 1'h0;
		repeat (3) @(negedge aclk);
		check("chan ticks", {28'h0, chan_clk_tick}, 34'h3F);
		// joined even channels follow the odd select; scaled ticks are rare at scale zero
		wr(8'h14, 8'h50, RESP_OKAY);
		wr(8'h08, 8'h0A, RESP_OKAY);
		do @(negedge aclk); while (tks[3:2] !== 2'h0);
		check("joined ticks", {28'h0, chan_clk_tick}, 34'h34);
		foreach (tr[i]) begin
			wr(tr[i], 8'hA5, RESP_OKAY);
			rd(tr[i], 8'h00, RESP_OKAY);
			@(posedge aclk);
			special_mode <= 1'h1;
			wr(tr[i], 8'h5A, RESP_OKAY);
			rd(tr[i], 8'h5A, RESP_OKAY);
			@(posedge aclk);
			special_mode <= 1'h0;
			rd(tr[i], 8'h00, RESP_OKAY);
		end
		wr(8'h28, 8'h11, RESP_SLVERR);
		rd(8'h28, 8'h00, RESP_SLVERR);
		// A and B selects run opposite ways so a swap shows
		for (int s = 0; s < 8; s++) begin
			wr(8'h0C, 8'(((7 - s) << 4) | s), RESP_OKAY);
			period(0, n);
			check("clock A", 34'(n), 34'(1 << s));
			period(1, n);
			check("clock B", 34'(n), 34'(1 << (7 - s)));
		end
		wr(8'h0C, 8'h10, RESP_OKAY);
		for (int j = 0; j < 2; j++) begin
			for (int t = 0; t < 3; t++) begin
				v = t == 0 ? 8'h03 : t == 1 ? 8'h00 : 8'($urandom_range(1, 40));
				wr(8'h20 + 8'(4 * j), v, RESP_OKAY);
				rd(8'h20 + 8'(4 * j), v, RESP_OKAY);
				period(2 + j, n);
				check("scaled", 34'(n), 34'((v == 0 ? 256 : v) * 2 * (j + 1)));
			end
			wr(8'h20 + 8'(4 * j), 8'hC8, RESP_OKAY);
			wr(8'h20 + 8'(4 * j), 8'h02, RESP_OKAY);
			n = 0;
			while (tks[2 + j] !== 1'h1 && n < 600) begin
				@(negedge aclk);
				n++;
			end
			check("reload", 34'(n <= 12 * (j + 1)), 34'h1);
		end
		finish_test();
	end
endmodule

`default_nettype wire
